/* File: design/emb_pkg.sv */
// shared constants, shape encodings and carriers for the embedded memory block
// assumes a single core clock; fabric ports are sampled into that domain
package emb_pkg;

	// storage size, fixed whatever the shape
	localparam int TOTAL_BITS  = 4096;
	localparam int PHYS_WIDTH  = 16;
	localparam int PHYS_DEPTH  = 256;
	localparam int ROW_BITS    = 8;
	localparam int PORT_ADDR_W = 11;
	localparam int SYNC_STAGES = 3;

	// data widths of the four shapes
	localparam int WIDTH_256X16 = 16;
	localparam int WIDTH_512X8  = 8;
	localparam int WIDTH_1024X4 = 4;
	localparam int WIDTH_2048X2 = 2;

	// lane select bits below the row address
	localparam int LANES_256X16 = 0;
	localparam int LANES_512X8  = 1;
	localparam int LANES_1024X4 = 2;
	localparam int LANES_2048X2 = 3;

	// reset value of the read data output
	localparam logic [15:0] READ_DATA_RESET = 16'h0000;
	// contents of location 0, which preload never touches
	localparam logic [15:0] ROW0_RESET      = 16'h0000;

	typedef enum {
		SHAPE_256X16,
		SHAPE_512X8,
		SHAPE_1024X4,
		SHAPE_2048X2
	} emb_shape_t;

	// one write request as seen on the fabric side
	typedef struct packed {
		logic        we;
		logic        clke;
		logic [10:0] addr;
		logic [15:0] data;
		logic [15:0] mask;
	} emb_wr_t;

	// one read request as seen on the fabric side
	typedef struct packed {
		logic        re;
		logic        clke;
		logic [10:0] addr;
	} emb_rd_t;

	function automatic int emb_data_width(emb_shape_t s);
		case (s)
			SHAPE_256X16: return WIDTH_256X16;
			SHAPE_512X8:  return WIDTH_512X8;
			SHAPE_1024X4: return WIDTH_1024X4;
			default:      return WIDTH_2048X2;
		endcase
	endfunction

	function automatic int emb_lane_bits(emb_shape_t s);
		case (s)
			SHAPE_256X16: return LANES_256X16;
			SHAPE_512X8:  return LANES_512X8;
			SHAPE_1024X4: return LANES_1024X4;
			default:      return LANES_2048X2;
		endcase
	endfunction

endpackage

/* File: design/emb_block_ram.sv */
// embedded 4 Kbit block memory: one write port, one read port, shape by parameter
// assumes fabric clocks and signals arrive asynchronously to core_clk and
// each fabric clock phase lasts at least three core_clk cycles
//
`timescale 1ns/1ps
`default_nettype none

// three-stage input synchroniser; stage one feeds stage two only
module emb_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] stage2,
	output logic      [WIDTH-1:0] stage3
);

	logic [WIDTH-1:0] stage1;

	// plain shift chain, cleared by reset
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end
		else
		begin
			stage1 <= din;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

endmodule

// Notes on behaviour
// R01 - array holds 4 Kbit in every shape
// R02 - separate write port and read port
// R03 - four shapes, mask only when 16 wide
// R04 - 16-wide write address picks one of 256
// R05 - 16-wide read address picks one of 256
// R06 - mask bit 0 stores, 1 keeps old
// R07 - data and addresses registered on port edge
// R08 - write edge rising, falling by option
// R09 - read edge rising, own falling option
// R10 - write needs enable and clock enable
// R11 - read needs enable and clock enable
// R12 - optional preload at configuration
// R13 - preloaded with writes locked acts as ROM
// R14 - location zero never preloaded
// R15 - fabric builds wider or deeper memories
// R16 - read data holds without enabled read
// R17 - all enables active high, per edge
module emb_block_ram #(
	parameter emb_pkg::emb_shape_t SHAPE         = emb_pkg::SHAPE_256X16,
	parameter bit                  WRITE_FALLING = 1'b0,
	parameter bit                  READ_FALLING  = 1'b0,
	parameter bit                  PRELOAD       = 1'b0,
	parameter bit                  ROM_MODE      = 1'b0,
	parameter logic [4095:0]       INIT_CONTENT  = '0
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        write_clock_in,
	input  wire logic        write_enable,
	input  wire logic        write_clock_enable,
	input  wire logic [10:0] write_address_in,
	input  wire logic [15:0] write_data_in,
	input  wire logic [15:0] write_mask_in,
	input  wire logic        read_clock_in,
	input  wire logic        read_enable,
	input  wire logic        read_clock_enable,
	input  wire logic [10:0] read_address_in,
	output logic      [15:0] read_data_out
);

	// shape-derived geometry
	localparam int DATA_W    = emb_pkg::emb_data_width(SHAPE);
	localparam int LANE_BITS = emb_pkg::emb_lane_bits(SHAPE);
	localparam int ADDR_W    = emb_pkg::ROW_BITS + LANE_BITS;
	localparam int WR_W      = $bits(emb_pkg::emb_wr_t);
	localparam int RD_W      = $bits(emb_pkg::emb_rd_t);
	localparam logic [10:0] ADDR_MASK = 11'((12'h001 << ADDR_W) - 12'h001);
	localparam logic [10:0] LANE_MASK = 11'((12'h001 << LANE_BITS) - 12'h001);
	localparam logic [15:0] WORD_MASK = 16'((17'h00001 << DATA_W) - 17'h00001);
	localparam bit          IS_WIDE   = (SHAPE == emb_pkg::SHAPE_256X16);
	localparam logic        WR_ACTIVE = ~WRITE_FALLING;
	localparam logic        RD_ACTIVE = ~READ_FALLING;

	// preload image; row zero is left out on purpose, and a declaration
	// initialiser keeps the array single-driven by the write process
	typedef logic [15:0] emb_rows_t [0:emb_pkg::PHYS_DEPTH-1];

	function automatic emb_rows_t emb_preload();
		emb_rows_t rows;
		rows[0] = emb_pkg::ROW0_RESET; // R14
		for (int r = 1; r < emb_pkg::PHYS_DEPTH; r++)
			rows[r] = PRELOAD ? INIT_CONTENT[r*emb_pkg::PHYS_WIDTH +: 16] : 16'h0000; // R12
		return rows;
	endfunction

	// storage: 256 rows of 16 keep 4 Kbit whatever the shape
	logic [15:0] mem [0:emb_pkg::PHYS_DEPTH-1] = emb_preload(); // R01

	emb_pkg::emb_wr_t wr_in;
	emb_pkg::emb_rd_t rd_in;
	logic [WR_W:0]    wr_s2;
	logic [WR_W:0]    wr_s3;
	logic [RD_W:0]    rd_s2;
	logic [RD_W:0]    rd_s3;
	emb_pkg::emb_wr_t wr_req;
	emb_pkg::emb_rd_t rd_req;
	logic             wclk_s2;
	logic             wclk_s3;
	logic             rclk_s2;
	logic             rclk_s3;
	logic             wclk_level;
	logic             rclk_level;
	logic             w_change;
	logic             r_change;
	logic             w_active;
	logic             r_active;

	// capture registers in front of the array
	logic        wr_go;
	logic [10:0] wr_addr;
	logic [15:0] wr_data;
	logic [15:0] wr_mask;
	logic        rd_go;
	logic [10:0] rd_addr;

	logic [7:0]  wr_row;
	logic [3:0]  wr_offset;
	logic [15:0] eff_mask;
	logic [15:0] eff_data;
	logic [7:0]  rd_row;
	logic [3:0]  rd_offset;
	logic [15:0] next_read_data;

	// fabric request bundles; narrow shapes ignore the mask pins
	always_comb
	begin
		wr_in.we   = write_enable;
		wr_in.clke = write_clock_enable;
		wr_in.addr = write_address_in & ADDR_MASK; // R03 R04
		wr_in.data = write_data_in;
		wr_in.mask = IS_WIDE ? write_mask_in : 16'h0000; // R03
		rd_in.re   = read_enable;
		rd_in.clke = read_clock_enable;
		rd_in.addr = read_address_in & ADDR_MASK; // R03 R05
	end

	// clocks travel with their data so both see the same delay
	emb_sync #(
		.WIDTH (WR_W + 1)
	) u_wr_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.din      ({write_clock_in, wr_in}),
		.stage2   (wr_s2),
		.stage3   (wr_s3)
	);

	emb_sync #(
		.WIDTH (RD_W + 1)
	) u_rd_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.din      ({read_clock_in, rd_in}),
		.stage2   (rd_s2),
		.stage3   (rd_s3)
	);

	// split synchronised bundles
	assign wclk_s2 = wr_s2[WR_W];
	assign wclk_s3 = wr_s3[WR_W];
	assign wr_req  = wr_s3[WR_W-1:0];
	assign rclk_s2 = rd_s2[RD_W];
	assign rclk_s3 = rd_s3[RD_W];
	assign rd_req  = rd_s3[RD_W-1:0];

	// a clock change counts once stages two and three agree
	assign w_change = (wclk_s2 == wclk_s3) && (wclk_s3 != wclk_level);
	assign r_change = (rclk_s2 == rclk_s3) && (rclk_s3 != rclk_level);
	assign w_active = w_change && (wclk_s3 == WR_ACTIVE); // R08
	assign r_active = r_change && (rclk_s3 == RD_ACTIVE); // R09

	// filtered write clock level
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			wclk_level <= WR_ACTIVE;
		else if (w_change)
			wclk_level <= wclk_s3;
	end

	// filtered read clock level, independent of the write side
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			rclk_level <= RD_ACTIVE;
		else if (r_change)
			rclk_level <= rclk_s3;
	end

	// write port input registers; address, data and mask loaded on the active edge only, wr_go every cycle
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			wr_go   <= 1'b0;
			wr_addr <= 11'h000;
			wr_data <= 16'h0000;
			wr_mask <= 16'hFFFF;
		end
		else
		begin
			// both enables high, else the edge is a no-op; ROM locks writes
			wr_go <= w_active && wr_req.we && wr_req.clke && !ROM_MODE; // R10 R17 R13
			if (w_active)
			begin
				wr_addr <= wr_req.addr; // R07
				wr_data <= wr_req.data; // R07
				wr_mask <= wr_req.mask;
			end
		end
	end

	// read port input registers
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			rd_go   <= 1'b0;
			rd_addr <= 11'h000;
		end
		else
		begin
			rd_go <= r_active && rd_req.re && rd_req.clke; // R11 R17
			if (r_active)
				rd_addr <= rd_req.addr; // R07
		end
	end

	// row and lane split of the captured write address
	always_comb
	begin
		wr_row    = 8'(wr_addr >> LANE_BITS);
		wr_offset = 4'((wr_addr & LANE_MASK) * DATA_W);
		if (IS_WIDE)
			eff_mask = wr_mask; // R06
		else
			eff_mask = ~(WORD_MASK << wr_offset);
		eff_data = (wr_data & WORD_MASK) << wr_offset;
	end

	// bit-masked array write; memory itself has no reset
	always_ff @(posedge core_clk)
	begin
		if (wr_go)
		begin
			for (int b = 0; b < emb_pkg::PHYS_WIDTH; b++)
				if (!eff_mask[b])
					mem[wr_row][b] <= eff_data[b]; // R06
		end
	end

	// read lane select; same-cycle write to the row returns old contents
	always_comb
	begin
		rd_row         = 8'(rd_addr >> LANE_BITS);
		rd_offset      = 4'((rd_addr & LANE_MASK) * DATA_W);
		next_read_data = (mem[rd_row] >> rd_offset) & WORD_MASK;
	end

	// read data register holds between enabled reads
	always_ff @(posedge core_clk)
	begin
		if (!rst_b)
			read_data_out <= emb_pkg::READ_DATA_RESET;
		else if (rd_go)
			read_data_out <= next_read_data; // R02 R11
		// else hold the last enabled read: R16
	end

	// checks
	default clocking emb_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	sequence wr_request_s;
		w_active && wr_req.we && wr_req.clke;
	endsequence

	sequence rd_request_s;
		r_active && rd_req.re && rd_req.clke;
	endsequence

	// pin history as stages two and three saw it at an accepted edge
	sequence wclk_pin_active_s;
		$past(write_clock_in, 3) == WR_ACTIVE && $past(write_clock_in, 2) == WR_ACTIVE;
	endsequence

	sequence rclk_pin_active_s;
		$past(read_clock_in, 3) == RD_ACTIVE && $past(read_clock_in, 2) == RD_ACTIVE;
	endsequence

	AST_WR_NEEDS_BOTH: assert property (wr_go |-> $past(w_active && wr_req.we && wr_req.clke)) // R10
		else $error("write without both enables on an active edge");

	AST_WR_TAKEN: assert property (wr_request_s ##0 !ROM_MODE |=> wr_go ##0 wr_addr == $past(wr_req.addr)) // R07
		else $error("write request not captured");

	AST_RD_TAKEN: assert property (rd_request_s |=> rd_go ##1 read_data_out == $past(next_read_data)) // R11
		else $error("read request did not update read data");

	AST_RD_HOLD: assert property (!rd_go |=> $stable(read_data_out)) // R16
		else $error("read data moved without an enabled read");

	AST_WR_POLARITY: assert property (w_active |-> wclk_pin_active_s) // R08
		else $error("write edge polarity wrong");

	AST_RD_POLARITY: assert property (r_active |-> rclk_pin_active_s) // R09
		else $error("read edge polarity wrong");

	AST_EDGE_SETTLED: assert property (w_active |-> wclk_s2 == wclk_s3) // R07
		else $error("write edge taken before synchroniser settled");

	AST_ROM_LOCK: assert property (ROM_MODE |-> !wr_go) // R13
		else $error("write reached the array in rom mode");

	AST_MASK_KEEPS: assert property (wr_go |=> ((mem[$past(wr_row)] ^ $past(mem[wr_row])) & $past(eff_mask)) == 16'h0000) // R06
		else $error("masked bit changed");

	AST_MASK_STORES: assert property (wr_go |=> (mem[$past(wr_row)] & ~$past(eff_mask)) == ($past(eff_data) & ~$past(eff_mask))) // R06
		else $error("unmasked bit not stored");

	AST_ADDR_RANGE: assert property (rd_go |-> (rd_addr & ~ADDR_MASK) == 11'h000) // R03
		else $error("read address beyond shape depth");

	AST_WR_REFUSED: assert property (w_active && !(wr_req.we && wr_req.clke) |=> !wr_go) // R10 R17
		else $error("write taken with an enable low");

	AST_RD_REFUSED: assert property (r_active && !(rd_req.re && rd_req.clke) |=> !rd_go) // R11 R17
		else $error("read taken with an enable low");

endmodule

`default_nettype wire

/* File: bench/emb_fabric.sv */
// fabric user logic model driving the write and read ports of the block
// assumes core_clk runs free; fabric clocks idle low between requests
`timescale 1ns/1ps
`default_nettype none

module emb_fabric (
	input  wire logic        core_clk,
	output logic             wclk,
	output logic             rclk,
	output emb_pkg::emb_wr_t wr,
	output emb_pkg::emb_rd_t rd
);
	// three core cycles per phase is the floor, four leaves margin
	localparam int PHASE = 4;

	// quiet levels at time zero
	initial
	begin
		wclk = 1'b0;
		rclk = 1'b0;
		wr   = '0;
		rd   = '0;
	end

	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// one write edge, controls held across the whole pulse
	task automatic write(input logic [10:0] a, input logic [15:0] d, input logic [15:0] m,
		input logic we, input logic ce);
		wr <= '{we, ce, a, d, m};
		idle(PHASE);
		wclk <= 1'b1;
		idle(PHASE);
		wclk <= 1'b0;
		idle(PHASE);
		// released address, data and mask lines show the inverse; both enables drop low
		wr <= '{1'b0, 1'b0, ~a, ~d, ~m};
		idle(1);
	endtask

	// one read edge; data is settled once the task returns
	task automatic read(input logic [10:0] a, input logic re, input logic ce);
		rd <= '{re, ce, a};
		idle(PHASE);
		rclk <= 1'b1;
		idle(PHASE);
		rclk <= 1'b0;
		idle(PHASE);
		rd <= '{1'b0, 1'b0, ~a};
		idle(1);
	endtask
endmodule

`default_nettype wire

/* File: bench/tb_top.sv */
// testbench: three blocks share one fabric model; 256x16 rising,
// 512x8 falling on inverted fabric clocks, and a preloaded ROM
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic             core_clk;
	logic             rst_b;
	logic             wclk;
	logic             rclk;
	emb_pkg::emb_wr_t wr;
	emb_pkg::emb_rd_t rd;
	logic [15:0]      rdata [3];
	int               error_cnt;
	int               tests_run;

	emb_fabric i_fab (
		.core_clk(core_clk),
		.wclk    (wclk),
		.rclk    (rclk),
		.wr      (wr),
		.rd      (rd)
	);

	// inverted clocks on the falling instance give the same fabric timing
	for (genvar i = 0; i < 3; i++)
	begin : g_dut
		emb_block_ram #(
			.SHAPE        (i == 1 ? emb_pkg::SHAPE_512X8 : emb_pkg::SHAPE_256X16),
			.WRITE_FALLING(i == 1),
			.READ_FALLING (i == 1),
			.PRELOAD      (i == 2),
			.ROM_MODE     (i == 2),
			.INIT_CONTENT ({256{16'hC35A}})
		) i_dut (
			.core_clk          (core_clk),
			.rst_b             (rst_b),
			.write_clock_in    (wclk ^ (i == 1)),
			.write_enable      (wr.we),
			.write_clock_enable(wr.clke),
			.write_address_in  (wr.addr),
			.write_data_in     (wr.data),
			.write_mask_in     (wr.mask),
			.read_clock_in     (rclk ^ (i == 1)),
			.read_enable       (rd.re),
			.read_clock_enable (rd.clke),
			.read_address_in   (rd.addr),
			.read_data_out     (rdata[i])
		);
	end

	// 40 MHz core clock
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// fabric-built 512x16: address bit 8 picks the block, read data muxed
	function automatic logic [15:0] casc_read(input logic [10:0] a);
		return a[8] ? rdata[2] : rdata[0];
	endfunction

	// one read on all three blocks, then compare each
	task automatic rchk(input logic [10:0] a, input logic re, input logic ce,
		input logic [15:0] e16, input logic [15:0] e8, input logic [15:0] erom);
		i_fab.read(a, re, ce);
		check(rdata[0], e16);
		check(rdata[1], e8);
		check(rdata[2], erom);
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// whole run is some 250 core cycles; a hang is cut far beyond that
	initial
	begin
		repeat (5000) @(posedge core_clk);
		error_cnt++;
		print_verdict();
	end

	// main sequence
	initial
	begin
		error_cnt = 0;
		tests_run = 0;
		rst_b     = 1'b0;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		i_fab.idle(4);
		rchk(11'h000, 1'b1, 1'b1, 16'h0000, 16'h0000, 16'h0000);
		rchk(11'h001, 1'b1, 1'b1, 16'h0000, 16'h0000, 16'hC35A);
		i_fab.write(11'h005, 16'hA5C3, 16'h0000, 1'b1, 1'b1);
		rchk(11'h005, 1'b1, 1'b1, 16'hA5C3, 16'h00C3, 16'hC35A);
		i_fab.write(11'h005, 16'h1234, 16'hFF00, 1'b1, 1'b1);
		rchk(11'h005, 1'b1, 1'b1, 16'hA534, 16'h0034, 16'hC35A);
		i_fab.write(11'h005, 16'hFFFF, 16'h0000, 1'b0, 1'b1);
		i_fab.write(11'h005, 16'hFFFF, 16'h0000, 1'b1, 1'b0);
		rchk(11'h005, 1'b1, 1'b1, 16'hA534, 16'h0034, 16'hC35A);
		i_fab.write(11'h004, 16'h00BE, 16'h0000, 1'b1, 1'b1);
		rchk(11'h004, 1'b1, 1'b1, 16'h00BE, 16'h00BE, 16'hC35A);
		rchk(11'h005, 1'b1, 1'b1, 16'hA534, 16'h0034, 16'hC35A);
		i_fab.write(11'h0FF, 16'h8001, 16'h0000, 1'b1, 1'b1);
		rchk(11'h0FF, 1'b1, 1'b1, 16'h8001, 16'h0001, 16'hC35A);
		check(casc_read(11'h0FF), 16'h8001);
		rchk(11'h1FF, 1'b1, 1'b1, 16'h8001, 16'h0000, 16'hC35A);
		check(casc_read(11'h1FF), 16'hC35A);
		rchk(11'h004, 1'b0, 1'b1, 16'h8001, 16'h0000, 16'hC35A);
		rchk(11'h004, 1'b1, 1'b0, 16'h8001, 16'h0000, 16'hC35A);
		print_verdict();
	end
endmodule

`default_nettype wire
